// File: gcl_pkg.sv
// Notes on behaviour
// - Synthesizer runs E1 rate on rate select 0, T1/J1 rate on 1.
// - Mute forces data outputs low on channels in signal loss; clock runs.
// - Extended window declares signal loss after 4096 consecutive zeros.
// - Normal window: 175+75 zeros in T1, 32 zeros in E1.
`default_nettype none
package gcl_pkg;
	// ----------------------------------------------------------------
	// Register layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam logic [6:0] GLOBAL_CLOCK_AND_LOS_CONTROL_ADDR = 7'h41;
	localparam int RATE_BIT = 7;
	localparam int CLKSEL_HI = 6;
	localparam int CLKSEL_LO = 3;
	localparam int SILENCE_BIT = 2;
	localparam int EXTWIN_BIT = 1;
	localparam int SPARE_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// ----------------------------------------------------------------
	// Zero-count thresholds, in received bits
	// ----------------------------------------------------------------
	localparam int ZCNT_W = 13;
	localparam logic [12:0] THRESH_EXTENDED = 13'(4096);
	localparam logic [12:0] THRESH_T1 = 13'(175 + 75);
	localparam logic [12:0] THRESH_E1 = 13'(32);
endpackage
`default_nettype wire

// File: gcl_los_chan.sv
`timescale 1ns/10ps
`default_nettype none
// Per-channel zero counter, loss flag and output mute
module gcl_los_chan (
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous reset
	input wire logic bit_en, // One received bit this cycle
	input wire logic pos_in, // Recovered positive data
	input wire logic neg_in, // Recovered negative data
	input wire logic [12:0] thresh, // Zero count that declares loss
	input wire logic silence, // Mute outputs during loss
	output logic loss, // Signal loss flag
	output logic pos_out, // Muted positive data
	output logic neg_out // Muted negative data
);
	logic [12:0] zcnt_r, zcnt_nxt;
	logic loss_r, loss_nxt, pos_r, pos_nxt, neg_r, neg_nxt;

	// Count zeros, restart and clear loss on activity
	always_comb begin
		zcnt_nxt = zcnt_r;
		loss_nxt = loss_r;
		if (bit_en) begin
			if (pos_in || neg_in) begin
				zcnt_nxt = '0;
				loss_nxt = 1'b0;
			end else if (zcnt_r + 13'h0001 >= thresh) begin
				zcnt_nxt = thresh;
				loss_nxt = 1'b1;
			end else begin
				zcnt_nxt = zcnt_r + 13'h0001;
			end
		end
		pos_nxt = (silence && loss_nxt) ? 1'b0 : pos_in;
		neg_nxt = (silence && loss_nxt) ? 1'b0 : neg_in;
	end

	// Register state
	always_ff @(posedge clk) begin
		if (reset) begin
			zcnt_r <= '0;
			loss_r <= 1'b0;
			pos_r <= 1'b0;
			neg_r <= 1'b0;
		end else begin
			zcnt_r <= zcnt_nxt;
			loss_r <= loss_nxt;
			pos_r <= pos_nxt;
			neg_r <= neg_nxt;
		end
	end

	assign loss = loss_r;
	assign pos_out = pos_r;
	assign neg_out = neg_r;

	a_mute_output: assert property (@(posedge clk) disable iff (reset)
		($past(silence) && loss_r) |-> (!pos_r && !neg_r))
		else $error("data not muted during loss");
	a_one_clears_loss: assert property (@(posedge clk) disable iff (reset)
		(bit_en && (pos_in || neg_in)) |=> (!loss_r && zcnt_r == 13'h0000))
		else $error("activity did not clear loss");
	a_no_early_loss: assert property (@(posedge clk) disable iff (reset)
		$rose(loss_r) |-> $past(zcnt_r) + 13'h0001 >= $past(thresh))
		else $error("loss declared before threshold");
endmodule
`default_nettype wire

// File: gcl_global_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Global clock-rate and signal-loss control register with four loss channels
module gcl_global_ctrl #(
	parameter int CHANNELS = 4
) (
	input wire logic CLK, // 200 MHz clock
	input wire logic RESET, // Synchronous reset, active high
	input wire logic [6:0] ADDR, // Register address
	input wire logic [7:0] WDATA, // Write data
	input wire logic WR, // Write strobe, one cycle
	input wire logic RD, // Read strobe, one cycle
	output logic [7:0] RDATA, // Read data, registered
	input wire logic [CHANNELS-1:0] BIT_EN, // Per channel bit timing
	input wire logic [CHANNELS-1:0] RX_POS_IN, // Recovered positive data
	input wire logic [CHANNELS-1:0] RX_NEG_IN, // Recovered negative data
	output logic [CHANNELS-1:0] RX_POSITIVE_OUT, // Positive data out
	output logic [CHANNELS-1:0] RX_NEGATIVE_VIOLATION_OUT, // Negative data out
	output logic [CHANNELS-1:0] RX_SIGNAL_LOSS, // Per channel loss
	output logic MASTER_RATE_SELECT, // 0 E1, 1 T1/J1 synthesizer rate
	output logic [3:0] CLOCK_SELECT // Synthesizer input clock select
);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad
		$error("CHANNELS must be 1..8");
	end

	// ----------------------------------------------------------------
	// Synchronisers for pin inputs
	// ----------------------------------------------------------------
	logic [CHANNELS-1:0] en_s1_r, en_s2_r, pos_s1_r, pos_s2_r, neg_s1_r, neg_s2_r;
	logic [CHANNELS-1:0] en_s3_r, en_pulse;
	logic [CHANNELS-1:0] en_s1_nxt, en_s2_nxt, en_s3_nxt;
	logic [CHANNELS-1:0] pos_s1_nxt, pos_s2_nxt, neg_s1_nxt, neg_s2_nxt;

	// Next stage values: each stage takes the one before it
	always_comb begin
		en_s1_nxt = BIT_EN;
		en_s2_nxt = en_s1_r;
		en_s3_nxt = en_s2_r;
		pos_s1_nxt = RX_POS_IN;
		pos_s2_nxt = pos_s1_r;
		neg_s1_nxt = RX_NEG_IN;
		neg_s2_nxt = neg_s1_r;
	end

	// Two flops per pin, third for edge of bit timing
	always_ff @(posedge CLK) begin
		if (RESET) begin
			en_s1_r <= '0;
			en_s2_r <= '0;
			en_s3_r <= '0;
			pos_s1_r <= '0;
			pos_s2_r <= '0;
			neg_s1_r <= '0;
			neg_s2_r <= '0;
		end else begin
			en_s1_r <= en_s1_nxt;
			en_s2_r <= en_s2_nxt;
			en_s3_r <= en_s3_nxt;
			pos_s1_r <= pos_s1_nxt;
			pos_s2_r <= pos_s2_nxt;
			neg_s1_r <= neg_s1_nxt;
			neg_s2_r <= neg_s2_nxt;
		end
	end

	// Rising edge of the synchronised bit timing marks one received bit
	assign en_pulse = en_s2_r & ~en_s3_r;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	logic [7:0] ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
	logic hit;
	logic [12:0] thresh;

	// Whole byte is written; the host keeps the two groups apart
	always_comb begin
		hit = (ADDR == gcl_pkg::GLOBAL_CLOCK_AND_LOS_CONTROL_ADDR);
		ctrl_nxt = ctrl_r;
		rdata_nxt = rdata_r;
		if (WR && hit) begin
			// Clock-select field and other bits share one byte
			ctrl_nxt = WDATA;
		end
		if (RD) begin
			rdata_nxt = hit ? ctrl_r : 8'h00;
		end
	end

	// Register the control byte and read data
	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctrl_r <= gcl_pkg::CTRL_RESET;
			rdata_r <= 8'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Loss threshold by window and rate
	always_comb begin
		if (ctrl_r[gcl_pkg::EXTWIN_BIT]) begin
			thresh = gcl_pkg::THRESH_EXTENDED;
		end else if (ctrl_r[gcl_pkg::RATE_BIT]) begin
			thresh = gcl_pkg::THRESH_T1;
		end else begin
			thresh = gcl_pkg::THRESH_E1;
		end
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		gcl_los_chan u_chan (
			.clk(CLK),
			.reset(RESET),
			.bit_en(en_pulse[i]),
			.pos_in(pos_s2_r[i]),
			.neg_in(neg_s2_r[i]),
			.thresh(thresh),
			.silence(ctrl_r[gcl_pkg::SILENCE_BIT]),
			.loss(RX_SIGNAL_LOSS[i]),
			.pos_out(RX_POSITIVE_OUT[i]),
			.neg_out(RX_NEGATIVE_VIOLATION_OUT[i])
		);

		// Data passes untouched on a channel that is not in loss
		a_clear_passes_data: assert property (@(posedge CLK) disable iff (RESET)
			!RX_SIGNAL_LOSS[i] |-> ((RX_POSITIVE_OUT[i] == $past(pos_s2_r[i]))
				&& (RX_NEGATIVE_VIOLATION_OUT[i] == $past(neg_s2_r[i]))))
			else $error("data changed outside loss");

		// Loss only rises on a received zero
		a_loss_on_zero: assert property (@(posedge CLK) disable iff (RESET)
			$rose(RX_SIGNAL_LOSS[i]) |-> ($past(en_pulse[i]) && !$past(pos_s2_r[i])
				&& !$past(neg_s2_r[i])))
			else $error("loss rose without a zero bit");

		// A counted bit comes from the pin two flops earlier
		a_bit_from_pin: assert property (@(posedge CLK) disable iff (RESET)
			en_pulse[i] |-> $past(BIT_EN[i], 2))
			else $error("bit pulse without pin edge");
	end

	// ----------------------------------------------------------------
	// Synthesizer and read outputs
	// ----------------------------------------------------------------
	// Synthesizer controls straight from the register
	assign MASTER_RATE_SELECT = ctrl_r[gcl_pkg::RATE_BIT];
	assign CLOCK_SELECT = ctrl_r[gcl_pkg::CLKSEL_HI:gcl_pkg::CLKSEL_LO];
	assign RDATA = rdata_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// A register write drives the synthesizer rate on the next cycle
	a_rate_follows_write: assert property (@(posedge CLK) disable iff (RESET)
		(WR && hit) |=> (MASTER_RATE_SELECT == $past(WDATA[7])))
		else $error("rate select not updated");

	// The clock-select field follows the written byte
	a_clksel_follows: assert property (@(posedge CLK) disable iff (RESET)
		(WR && hit) |=> (CLOCK_SELECT == $past(WDATA[6:3])))
		else $error("clock select not updated");

	// Mute, extended window and spare bits are stored as written
	a_low_bits_stored: assert property (@(posedge CLK) disable iff (RESET)
		(WR && hit) |=> (ctrl_r[2:0] == $past(WDATA[2:0])))
		else $error("low bits not stored");

	// Without a write to this register the byte holds
	a_ctrl_held: assert property (@(posedge CLK) disable iff (RESET)
		!(WR && hit) |=> $stable(ctrl_r))
		else $error("control byte changed without write");

	// Normal window in E1 operation
	a_thresh_e1: assert property (@(posedge CLK) disable iff (RESET)
		(!ctrl_r[1] && !ctrl_r[7]) |-> thresh == 13'h0020)
		else $error("E1 threshold wrong");

	// Normal window in T1/J1 operation
	a_thresh_t1: assert property (@(posedge CLK) disable iff (RESET)
		(!ctrl_r[1] && ctrl_r[7]) |-> thresh == 13'h00FA)
		else $error("T1 threshold wrong");

	// Extended window overrides the rate
	a_thresh_ext: assert property (@(posedge CLK) disable iff (RESET)
		ctrl_r[1] |-> thresh == 13'h1000)
		else $error("extended threshold wrong");

	// A read returns the stored byte
	a_read_back: assert property (@(posedge CLK) disable iff (RESET)
		(RD && hit && !WR) |=> RDATA == $past(ctrl_r))
		else $error("read back mismatch");

	// A read beside a write returns the old byte
	a_read_old_on_write: assert property (@(posedge CLK) disable iff (RESET)
		(RD && WR && hit) |=> RDATA == $past(ctrl_r))
		else $error("read beside write not old value");

	// Unmapped addresses read as zero
	a_unmapped_zero: assert property (@(posedge CLK) disable iff (RESET)
		(RD && !hit) |=> (RDATA == 8'h00))
		else $error("unmapped read not zero");

	// Read data stands until the next read
	a_rdata_holds: assert property (@(posedge CLK) disable iff (RESET)
		!RD |=> $stable(RDATA))
		else $error("read data changed without read");
endmodule
`default_nettype wire

// File: gcl_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host processor model on the parallel register port
module gcl_host (
	input wire logic clk, // Bus clock
	output logic [6:0] addr = 7'h00, // Register address
	output logic [7:0] wdata = 8'h00, // Write data
	output logic wr = 1'b0, // Write strobe
	output logic rd = 1'b0, // Read strobe
	input wire logic [7:0] rdata // Read data
);
	localparam logic [6:0] CA = gcl_pkg::GLOBAL_CLOCK_AND_LOS_CONTROL_ADDR;
	logic [7:0] shadow = 8'h00;
	// One strobed cycle; bus scrambled once released
	task automatic cyc(input logic [6:0] a, input logic [7:0] d, input logic w);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	// Read, data taken after the answer edge
	task automatic read(input logic [6:0] a, output logic [7:0] v);
		cyc(a, 8'h00, 1'b0);
		v = rdata;
	endtask
	// Sub-register update, split when both groups change
	task automatic update(input logic [7:0] nv, input logic clk_first);
		logic [7:0] mid;
		mid = clk_first ? {shadow[7], nv[6:3], shadow[2:0]} : {nv[7], shadow[6:3], nv[2:0]};
		if (mid != shadow && mid != nv) cyc(CA, mid, 1'b1);
		cyc(CA, nv, 1'b1);
		shadow = nv;
	endtask
endmodule
`default_nettype wire

// File: global_clock_rate_los_config_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module global_clock_rate_los_config_test;
	localparam logic [6:0] CA = gcl_pkg::GLOBAL_CLOCK_AND_LOS_CONTROL_ADDR;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic WR, RD, MRS;
	logic [6:0] ADDR;
	logic [7:0] WDATA, RDATA, v;
	logic [3:0] BIT_EN = 4'h0, RX_POS_IN = 4'h0, RX_NEG_IN = 4'h0, PO, NO, LOSS, CS;
	logic [31:0] lfsr = 32'h13DCA7E0;
	int num_errors = 0;
	int check_count = 0;
	// Clock, 5 ns period
	initial forever #2.5 CLK = ~CLK;
	gcl_host host (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD), .rdata(RDATA));
	gcl_global_ctrl dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .BIT_EN(BIT_EN), .RX_POS_IN(RX_POS_IN), .RX_NEG_IN(RX_NEG_IN),
		.RX_POSITIVE_OUT(PO), .RX_NEGATIVE_VIOLATION_OUT(NO), .RX_SIGNAL_LOSS(LOSS),
		.MASTER_RATE_SELECT(MRS), .CLOCK_SELECT(CS));
	// Next random word
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Send n received bits on all channels, then let syncs settle
	task automatic bits(input int n, input logic [3:0] p);
		repeat (n) begin
			@(negedge CLK);
			RX_POS_IN = p;
			BIT_EN = 4'hF;
			repeat (2) @(negedge CLK);
			BIT_EN = 4'h0;
			RX_POS_IN = 4'h0;
			@(negedge CLK);
		end
		repeat (6) @(negedge CLK);
	endtask
	// Loss must appear on exactly the th-th zero
	task automatic los(input int th);
		bits(1, 4'hF);
		bits(th - 1, 4'h0);
		`CHK(LOSS, 4'h0)
		bits(1, 4'h0);
		`CHK(LOSS, 4'hF)
	endtask
	// Verdict and end of run
	task automatic results;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(negedge CLK);
		RESET = 1'b0;
		host.read(CA, v);
		`CHK({v, MRS, CS, LOSS}, {gcl_pkg::CTRL_RESET, 9'h000})
		host.read(7'h40, v);
		`CHK(v, 8'h00)
		for (int i = 0; i < 12; i++) begin
			lfsr = step(lfsr);
			host.update(lfsr[7:0], i[0]);
			host.read(CA, v);
			`CHK({MRS, CS, v}, {lfsr[7:3], lfsr[7:0]})
		end
		host.cyc(7'h40, ~lfsr[7:0], 1'b1);
		host.read(CA, v);
		`CHK(v, lfsr[7:0])
		host.update(8'h04, 1'b0);
		los(32);
		RX_NEG_IN = 4'hF;
		RX_POS_IN = 4'hF;
		repeat (8) @(negedge CLK);
		`CHK({PO, NO}, 8'h00)
		RX_NEG_IN = 4'h0;
		lfsr = step(lfsr);
		bits(1, lfsr[3:0]);
		`CHK(LOSS, ~lfsr[3:0])
		RX_POS_IN = 4'hF;
		repeat (8) @(negedge CLK);
		`CHK(PO, lfsr[3:0])
		RX_POS_IN = 4'h0;
		host.update(8'h80, 1'b1);
		los(250);
		RX_POS_IN = 4'hF;
		RX_NEG_IN = lfsr[7:4];
		repeat (8) @(negedge CLK);
		`CHK({PO, NO}, {4'hF, lfsr[7:4]})
		RX_POS_IN = 4'h0;
		RX_NEG_IN = 4'h0;
		host.update(8'h82, 1'b0);
		los(4096);
		RESET = 1'b1;
		repeat (8) @(negedge CLK);
		RESET = 1'b0;
		host.shadow = 8'h00;
		host.read(CA, v);
		`CHK({v, MRS, CS, LOSS}, {gcl_pkg::CTRL_RESET, 9'h000})
		results;
	end
	// Watchdog
	initial begin
		#200000;
		num_errors++;
		results;
	end
endmodule
`default_nettype wire
